// file: axf_field_model.sv
// field side model: switch, servo and pulser lines with commanded glitch bursts
`timescale 1ns/1ps
module axf_field_model (
    input  wire logic                  clk,
    input  wire axf_pkg::axf_axis_in_t x_base,
    input  wire axf_pkg::axf_axis_in_t y_base,
    input  wire logic                  emg_base,
    input  wire logic [15:0]           glitch_mask,
    input  wire logic [7:0]            glitch_len,
    input  wire logic                  glitch_go,
    output axf_pkg::axf_axis_in_t      x_pin,
    output axf_pkg::axf_axis_in_t      y_pin,
    output logic                       emg_pin
);
    import axf_pkg::*;
    logic [7:0]  left_r = 8'h00;
    logic [15:0] inv;
    ////////////////////////////////////////////////////////////////////////////////
    // burst length counter; switch bounce is one burst, not a clean edge
    always_ff @(posedge clk) begin
        if (glitch_go) begin
            left_r <= glitch_len;
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end
    end
    // same burst on both axes so one stimulus proves both filter copies
    assign inv     = (left_r != 8'h00) ? glitch_mask : 16'h0000;
    assign x_pin   = axf_axis_in_t'(x_base ^ inv[14:0]);
    assign y_pin   = axf_axis_in_t'(y_base ^ inv[14:0]);
    assign emg_pin = emg_base ^ inv[15];
endmodule // axf_field_model

// file: axf_filt.sv
// one integrating input filter with its pin synchroniser
`timescale 1ns/1ps
`include "axf_map.svh"
module axf_filt (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic pin,
    input  wire logic tick,
    input  wire logic flt_en,
    output logic      level
);
    import axf_pkg::*;

    axf_filt_st_t st_r;
    axf_filt_st_t st_nxt;

    // sync, integrate on each tick, pick filtered or raw
    always_comb begin
        st_nxt    = st_r;
        st_nxt.sy = {st_r.sy[1:0], pin};
        // a change counts once stages two and three agree
        if (st_r.sy[1] == st_r.sy[2]) begin
            st_nxt.lvl = st_r.sy[2];
        end
        if (!flt_en) begin
            // track the raw level so enabling later causes no glitch
            st_nxt.cnt = st_r.lvl ? `AXF_INT_FULL : `AXF_INT_EMPTY;
            st_nxt.flt = st_r.lvl;
        end else if (tick) begin
            // short noise never walks the integrator to a bound
            if (st_r.lvl && st_r.cnt != `AXF_INT_FULL) begin
                st_nxt.cnt = st_r.cnt + 4'h1;
            end else if (!st_r.lvl && st_r.cnt != `AXF_INT_EMPTY) begin
                st_nxt.cnt = st_r.cnt - 4'h1;
            end
            if (st_nxt.cnt == `AXF_INT_FULL) begin
                st_nxt.flt = 1'b1;
            end else if (st_nxt.cnt == `AXF_INT_EMPTY) begin
                st_nxt.flt = 1'b0;
            end
        end
        st_nxt.out = flt_en ? st_r.flt : st_r.lvl;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.out;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_bypass;
        !flt_en |=> level == $past(st_r.lvl);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass output not raw level");

    property p_low_holds;
        (flt_en && !st_r.flt && !st_r.lvl) |=> !st_r.flt;
    endproperty
    a_low_holds: assert property (p_low_holds) else $error("filter rose on low input");

    property p_high_holds;
        (flt_en && st_r.flt && st_r.lvl) |=> st_r.flt;
    endproperty
    a_high_holds: assert property (p_high_holds) else $error("filter fell on high input");

    property p_agree;
        $changed(st_r.lvl) |-> $past(st_r.sy[1]) == $past(st_r.sy[2]);
    endproperty
    a_agree: assert property (p_agree) else $error("level changed without agreement");

endmodule // axf_filt

// file: axf_gpio.sv
// per-axis general io, shared output pins and input filter control
`timescale 1ns/1ps
`include "axf_map.svh"
module axf_gpio #(
    parameter logic [17:0] TICK0_CYC = 18'(`AXF_TICK0_NS * `AXF_CLK_MHZ / 1000),
    parameter logic [17:0] TICK1_CYC = 18'(`AXF_TICK1_NS * `AXF_CLK_MHZ / 1000)
) (
    input  wire logic                 REF_CLK,
    input  wire logic                 RESETN,
    input  wire logic                 WR_STB,
    input  wire logic [1:0]           WR_REG,
    input  wire logic                 WR_AXIS,
    input  wire logic [15:0]          WR_DATA,
    input  wire axf_pkg::axf_axis_in_t X_IN,
    input  wire axf_pkg::axf_axis_in_t Y_IN,
    input  wire logic                 EMG_IN,
    input  wire logic                 INTERP_ACTIVE,
    input  wire logic                 X_CMP_OUT_EN,
    input  wire logic                 Y_CMP_OUT_EN,
    input  wire logic [7:0]           X_CMP_OUT,
    input  wire logic [7:0]           Y_CMP_OUT,
    input  wire logic [7:0]           X_DRV_STATUS,
    input  wire logic [7:0]           Y_DRV_STATUS,
    output axf_pkg::axf_axis_in_t     X_FLT,
    output axf_pkg::axf_axis_in_t     Y_FLT,
    output logic                      EMG_FLT,
    output logic [15:0]               X_INPUT_STATUS,
    output logic [15:0]               Y_INPUT_STATUS,
    output logic [7:0]                X_OUT,
    output logic [7:0]                Y_OUT
);
    import axf_pkg::*;

    axf_state_t                          st_r;
    axf_state_t                          st_nxt;
    logic [1:0][`AXF_NSIG-1:0]           raw_in;
    logic [1:0][`AXF_NSIG-1:0]           grp_en;
    logic [1:0][`AXF_NSIG-1:0]           flt_out;
    logic [1:0]                          tick;
    logic [`AXF_PRESC_W-1:0]             per_x;
    logic [`AXF_PRESC_W-1:0]             per_y;
    axf_axis_in_t                        fx;
    axf_axis_in_t                        fy;
    logic [5:0]                          gin_x;
    logic [5:0]                          gin_y;
    logic                                emg_level;

    ////////////////////////////////////////////////////////////////////////////
    // filter time base

    // tick period per code; tick is one eighth of the delay
    function automatic logic [`AXF_PRESC_W-1:0] tick_period(input logic [2:0] sel);
        logic [`AXF_PRESC_W-1:0] p;
        p = TICK0_CYC;
        if (sel != 3'h0) begin
            p = TICK1_CYC << (sel - 3'h1);
        end
        return p;
    endfunction

    // time select per axis from the config field
    assign per_x   = tick_period(st_r.fcfg_x[`AXF_FL_MSB:`AXF_FL_LSB]);
    assign per_y   = tick_period(st_r.fcfg_y[`AXF_FL_MSB:`AXF_FL_LSB]);
    // counted in system clocks, so timing scales with the clock
    assign tick[0] = (st_r.presc_x >= per_x - 18'h1);
    assign tick[1] = (st_r.presc_y >= per_y - 18'h1);

    ////////////////////////////////////////////////////////////////////////////
    // filter bank

    assign raw_in[0] = X_IN;
    assign raw_in[1] = Y_IN;

    // group enables spread over the inputs of each axis
    assign grp_en[0] = {{6{st_r.fcfg_x[`AXF_FE4]}}, {2{st_r.fcfg_x[`AXF_FE3]}},
                        {2{st_r.fcfg_x[`AXF_FE2]}}, st_r.fcfg_x[`AXF_FE1], {4{st_r.fcfg_x[`AXF_FE0]}}};
    assign grp_en[1] = {{6{st_r.fcfg_y[`AXF_FE4]}}, {2{st_r.fcfg_y[`AXF_FE3]}},
                        {2{st_r.fcfg_y[`AXF_FE2]}}, st_r.fcfg_y[`AXF_FE1], {4{st_r.fcfg_y[`AXF_FE0]}}};

    // identical filter for each input of both axes
    for (genvar a = 0; a < 2; a++) begin : g_axis
        for (genvar b = 0; b < `AXF_NSIG; b++) begin : g_sig
            axf_filt u_filt (
                .ref_clk (REF_CLK),
                .resetn  (RESETN),
                .pin     (raw_in[a][b]),
                .tick    (tick[a]),
                .flt_en  (grp_en[a][b]),
                .level   (flt_out[a][b])
            );
        end
    end

    // shared emergency input uses X timing and the X enable only
    axf_filt u_emg (
        .ref_clk (REF_CLK),
        .resetn  (RESETN),
        .pin     (EMG_IN),
        .tick    (tick[0]),
        .flt_en  (st_r.fcfg_x[`AXF_FE0]),
        .level   (emg_level)
    );

    assign fx      = flt_out[0];
    assign fy      = flt_out[1];
    assign X_FLT   = fx;
    assign Y_FLT   = fy;
    assign EMG_FLT = emg_level;

    // interpolation link owns general inputs five to two
    always_comb begin
        gin_x = fx.gin;
        gin_y = fy.gin;
        if (INTERP_ACTIVE) begin
            gin_x[`AXF_GIN_LINK_MSB:`AXF_GIN_LINK_LSB] = 4'h0;
            gin_y[`AXF_GIN_LINK_MSB:`AXF_GIN_LINK_LSB] = 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers, pins and status

    // write decode, prescalers, pin mux and status capture
    always_comb begin
        st_nxt = st_r;
        if (WR_STB) begin
            if (WR_REG == `AXF_REG_MODE) begin
                if (WR_AXIS == `AXF_AXIS_X) begin
                    st_nxt.status_output_select_x = WR_DATA[`AXF_MODE_STATUS_OUTPUT_SELECT_BIT];
                end else begin
                    st_nxt.status_output_select_y = WR_DATA[`AXF_MODE_STATUS_OUTPUT_SELECT_BIT];
                end
            end else if (WR_REG == `AXF_REG_FCFG) begin
                if (WR_AXIS == `AXF_AXIS_X) begin
                    st_nxt.fcfg_x = WR_DATA[`AXF_FCFG_MSB:`AXF_FCFG_LSB];
                end else begin
                    st_nxt.fcfg_y = WR_DATA[`AXF_FCFG_MSB:`AXF_FCFG_LSB];
                end
            end else if (WR_REG == `AXF_REG_GPO) begin
                st_nxt.gpo = WR_DATA;
            end
        end
        // free-running tick counters; a code change takes effect within one period
        st_nxt.presc_x = tick[0] ? '0 : st_r.presc_x + 18'h1;
        st_nxt.presc_y = tick[1] ? '0 : st_r.presc_y + 18'h1;
        // status output wins, then comparison, then general levels
        if (st_r.status_output_select_x) begin
            st_nxt.pin_x = X_DRV_STATUS;
        end else if (X_CMP_OUT_EN) begin
            st_nxt.pin_x = X_CMP_OUT;
        end else begin
            st_nxt.pin_x = st_r.gpo[`AXF_GPO_X_MSB:`AXF_GPO_X_LSB];
        end
        if (st_r.status_output_select_y) begin
            st_nxt.pin_y = Y_DRV_STATUS;
        end else if (Y_CMP_OUT_EN) begin
            st_nxt.pin_y = Y_CMP_OUT;
        end else begin
            st_nxt.pin_y = st_r.gpo[`AXF_GPO_Y_MSB:`AXF_GPO_Y_LSB];
        end
        // high reads as one, other status bits belong elsewhere
        st_nxt.sts_x = `AXF_STS_RST;
        st_nxt.sts_y = `AXF_STS_RST;
        st_nxt.sts_x[`AXF_STS_GIN_MSB:`AXF_STS_GIN_LSB] = gin_x;
        st_nxt.sts_y[`AXF_STS_GIN_MSB:`AXF_STS_GIN_LSB] = gin_y;
    end

    // reset drops outputs low and bypasses every filter
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            st_r         <= '0;
            st_r.gpo     <= `AXF_GPO_RST;
            st_r.fcfg_x  <= `AXF_FCFG_RST;
            st_r.fcfg_y  <= `AXF_FCFG_RST;
            st_r.pin_x   <= `AXF_PIN_RST;
            st_r.pin_y   <= `AXF_PIN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // six inputs and eight outputs per axis
    assign X_INPUT_STATUS = st_r.sts_x;
    assign Y_INPUT_STATUS = st_r.sts_y;
    assign X_OUT          = st_r.pin_x;
    assign Y_OUT          = st_r.pin_y;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    sequence s_gpo_write;
        WR_STB && WR_REG == `AXF_REG_GPO;
    endsequence

    property p_gpo_write;
        s_gpo_write |=> st_r.gpo == $past(WR_DATA);
    endproperty
    a_gpo_write: assert property (p_gpo_write) else $error("level register missed write");

    property p_pin_gpo;
        (!st_r.status_output_select_x && !X_CMP_OUT_EN && !st_r.status_output_select_y && !Y_CMP_OUT_EN)
            |=> X_OUT == $past(st_r.gpo[7:0]) && Y_OUT == $past(st_r.gpo[15:8]);
    endproperty
    a_pin_gpo: assert property (p_pin_gpo) else $error("pins not from level register");

    property p_pin_drv;
        st_r.status_output_select_x |=> X_OUT == $past(X_DRV_STATUS);
    endproperty
    a_pin_drv: assert property (p_pin_drv) else $error("drive status not on shared pins");

    property p_rst_out;
        $rose(RESETN) |-> st_r.gpo == 16'h0000 && X_OUT == 8'h00 && Y_OUT == 8'h00;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not low after reset");

    property p_rst_fcfg;
        $rose(RESETN) |-> st_r.fcfg_x == 8'h00 && st_r.fcfg_y == 8'h00;
    endproperty
    a_rst_fcfg: assert property (p_rst_fcfg) else $error("filter config not cleared");

    property p_status_output_select;
        $rose(RESETN) |-> !st_r.status_output_select_x && !st_r.status_output_select_y;
    endproperty
    a_status_output_select: assert property (p_status_output_select) else $error("status select not cleared");

    property p_interp;
        INTERP_ACTIVE |=> X_INPUT_STATUS[13:10] == 4'h0 && Y_INPUT_STATUS[13:10] == 4'h0;
    endproperty
    a_interp: assert property (p_interp) else $error("link inputs shown as general");

    property p_status;
        1'b1 |=> X_INPUT_STATUS[9:8] == $past(fx.gin[1:0]) && Y_INPUT_STATUS[9:8] == $past(fy.gin[1:0]);
    endproperty
    a_status: assert property (p_status) else $error("status bits not input levels");

    property p_tick_gap;
        tick[0] |=> !tick[0] [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("filter tick too fast");

endmodule // axf_gpio

// file: axf_gpio_tb_top.sv
// self-checking bench of the axis gpio and input filter block
`timescale 1ns/1ps
`include "axf_map.svh"
module axf_gpio_tb_top;
    import axf_pkg::*;
    logic         ref_clk, resetn, wr_stb, wr_axis, interp, cmp_en_x, cmp_en_y, g_go, emg_pin, emg_flt;
    logic [1:0]   wr_reg;
    logic [15:0]  wr_data, g_mask, x_sts, y_sts;
    logic [7:0]   cmp_x, drv_x, g_len, x_out, y_out;
    axf_axis_in_t x_base, y_base, x_pin, y_pin, x_flt, y_flt;
    int           n_errors, checks_done;
    localparam logic [14:0] GRP [5] = '{15'h000F, 15'h0010, 15'h0060, 15'h0180, 15'h7E00};

    axf_field_model field (.clk(ref_clk), .x_base(x_base), .y_base(y_base), .emg_base(1'b0),
        .glitch_mask(g_mask), .glitch_len(g_len), .glitch_go(g_go), .x_pin(x_pin), .y_pin(y_pin),
        .emg_pin(emg_pin));
    // short prescaler counts keep the run short; code 0 stays above the eight-cycle tick gap
    axf_gpio #(.TICK0_CYC(18'h00009), .TICK1_CYC(18'h00012)) dut (.REF_CLK(ref_clk), .RESETN(resetn),
        .WR_STB(wr_stb), .WR_REG(wr_reg), .WR_AXIS(wr_axis), .WR_DATA(wr_data), .X_IN(x_pin),
        .Y_IN(y_pin), .EMG_IN(emg_pin), .INTERP_ACTIVE(interp), .X_CMP_OUT_EN(cmp_en_x),
        .Y_CMP_OUT_EN(cmp_en_y), .X_CMP_OUT(cmp_x), .Y_CMP_OUT(~cmp_x), .X_DRV_STATUS(drv_x),
        .Y_DRV_STATUS(~drv_x), .X_FLT(x_flt), .Y_FLT(y_flt), .EMG_FLT(emg_flt),
        .X_INPUT_STATUS(x_sts), .Y_INPUT_STATUS(y_sts), .X_OUT(x_out), .Y_OUT(y_out));

    // free running system clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [1:0] r, input logic a, input logic [15:0] d);
        @(posedge ref_clk);
        wr_stb  <= 1'b1;
        wr_reg  <= r;
        wr_axis <= a;
        wr_data <= d;
        @(posedge ref_clk);
        wr_stb  <= 1'b0;
    endtask
    task automatic cfg_both(input logic [15:0] x, input logic [15:0] y);
        wr(`AXF_REG_FCFG, `AXF_AXIS_X, x);
        wr(`AXF_REG_FCFG, `AXF_AXIS_Y, y);
    endtask
    // fire one burst and collect every filtered line that moved; base levels are low
    task automatic burst(input logic [15:0] m, input logic [7:0] len, input logic [30:0] exp);
        logic [30:0] seen;
        seen = '0;
        @(posedge ref_clk);
        g_mask <= m;
        g_len  <= len;
        g_go   <= 1'b1;
        @(posedge ref_clk);
        g_go   <= 1'b0;
        repeat (60) begin
            cyc(1);
            seen |= {emg_flt, y_flt, x_flt};
        end
        chk("moved lines", {1'b0, exp}, {1'b0, seen});
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_groups();
        burst(16'hFFFF, 8'h03, 31'h7FFFFFFF);
        for (int g = 0; g < 5; g++) begin
            cfg_both(16'hE000 | (16'h0100 << g), 16'hE000 | (16'h0100 << g));
            burst(16'hFFFF, 8'h03, {g != 0, ~GRP[g], ~GRP[g]});
        end
        cfg_both(16'h0000, 16'hE100);
        burst(16'hFFFF, 8'h03, {1'b1, ~GRP[0], 15'h7FFF});
        cfg_both(16'h1000, 16'h1000);
        burst(16'h0200, 8'h0C, 31'h00000000);
        $display("group enable test done");
    endtask
    // each code: step gin0 both ways and time the status bit
    task automatic test_delay();
        int p;
        int n;
        for (int k = 0; k < 8; k++) begin
            p = (k == 0) ? 9 : (18 << (k - 1));
            cfg_both(16'((k << 13) | 16'h1000), 16'h0000);
            for (int v = 1; v >= 0; v--) begin
                @(posedge ref_clk);
                x_base.gin[0] <= v[0];
                n = 0;
                while (x_sts !== {7'h00, v[0], 8'h00} && n < 10 * p + 20) begin
                    cyc(1);
                    n++;
                end
                chk("delay low bound", 32'h1, 32'(n >= 7 * p));
                chk("delay high bound", 32'h1, 32'(n <= 9 * p + 12));
                if (n >= 10 * p + 20) close_out();
            end
        end
        $display("filter delay test done");
    endtask
    task automatic test_status();
        cfg_both(16'h0000, 16'h0000);
        @(posedge ref_clk);
        x_base.gin <= 6'h2D;
        y_base.gin <= 6'h12;
        cyc(10);
        chk("x status", 32'h2D00, x_sts);
        chk("y status", 32'h1200, y_sts);
        @(posedge ref_clk);
        interp <= 1'b1;
        cyc(3);
        chk("x status linked", 32'h0100, x_sts);
        chk("y status linked", 32'h0200, y_sts);
        interp <= 1'b0;
        x_base.gin <= 6'h00;
        y_base.gin <= 6'h00;
        cyc(10);
        $display("input status test done");
    endtask
    task automatic test_outputs();
        chk("outputs after reset", 32'h0000, {y_out, x_out});
        wr(`AXF_REG_GPO, `AXF_AXIS_X, 16'hA55A);
        wr(2'h3, `AXF_AXIS_X, 16'hFFFF);
        cyc(2);
        chk("level outputs", 32'hA55A, {y_out, x_out});
        drv_x    <= 8'hC3;
        cmp_x    <= 8'hC3;
        cmp_en_x <= 1'b1;
        cmp_en_y <= 1'b1;
        wr(`AXF_REG_MODE, `AXF_AXIS_X, 16'h0080);
        cyc(2);
        chk("shared pins", 32'h3CC3, {y_out, x_out});
        @(posedge ref_clk);
        resetn <= 1'b0;
        cyc(4);
        chk("outputs in reset", 32'h0000, {y_out, x_out});
        resetn   <= 1'b1;
        cmp_en_x <= 1'b0;
        cmp_en_y <= 1'b0;
        wr(`AXF_REG_GPO, `AXF_AXIS_Y, 16'h00FF);
        cyc(2);
        chk("levels after reset", 32'h00FF, {y_out, x_out});
        $display("output test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {resetn, wr_stb, wr_axis, interp, cmp_en_x, cmp_en_y, g_go} = '0;
        {wr_reg, wr_data, g_mask, cmp_x, drv_x, g_len} = '0;
        x_base = '0;
        y_base = '0;
        n_errors = 0;
        checks_done = 0;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        cyc(2);
        test_groups();
        test_delay();
        test_status();
        test_outputs();
        close_out();
    end
endmodule // axf_gpio_tb_top

// file: axf_map.svh
// constants and field positions of the axis gpio and input filter block
`ifndef AXF_MAP_SVH
`define AXF_MAP_SVH

// write port register select codes
`define AXF_REG_MODE        2'h0
`define AXF_REG_FCFG        2'h1
`define AXF_REG_GPO         2'h2
`define AXF_AXIS_X          1'h0
`define AXF_AXIS_Y          1'h1

// register fields
`define AXF_MODE_STATUS_OUTPUT_SELECT_BIT  7
`define AXF_FCFG_MSB        15
`define AXF_FCFG_LSB        8
`define AXF_GPO_X_MSB       7
`define AXF_GPO_X_LSB       0
`define AXF_GPO_Y_MSB       15
`define AXF_GPO_Y_LSB       8
`define AXF_STS_GIN_MSB     13
`define AXF_STS_GIN_LSB     8
`define AXF_GIN_LINK_MSB    5
`define AXF_GIN_LINK_LSB    2

// fields of the stored filter config byte
`define AXF_FE0             0
`define AXF_FE1             1
`define AXF_FE2             2
`define AXF_FE3             3
`define AXF_FE4             4
`define AXF_FL_MSB          7
`define AXF_FL_LSB          5

// reset values
`define AXF_GPO_RST         16'h0000
`define AXF_FCFG_RST        8'h00
`define AXF_PIN_RST         8'h00
`define AXF_STS_RST         16'h0000

// timing: integrator spans eight ticks, tick is delay / 8
`define AXF_CLK_MHZ         125
`define AXF_TICK0_NS        250
`define AXF_TICK1_NS        32000
`define AXF_PRESC_W         18
`define AXF_INT_FULL        4'h8
`define AXF_INT_EMPTY       4'h0
`define AXF_NSIG            15

`endif

// file: axf_pkg.sv
// types of the axis gpio and input filter block
package axf_pkg;

    // filterable inputs of one axis, lsb first: limits, stops, servo, pulser, general
    typedef struct packed {
        logic [5:0] gin;
        logic       expm;
        logic       expp;
        logic       alarm;
        logic       inpos;
        logic       stop2;
        logic       stop1;
        logic       stop0;
        logic       lmtm;
        logic       lmtp;
    } axf_axis_in_t;

    // state of one filtered input
    typedef struct packed {
        logic [2:0] sy;
        logic       lvl;
        logic [3:0] cnt;
        logic       flt;
        logic       out;
    } axf_filt_st_t;

    // state of the top block
    typedef struct packed {
        logic [15:0] gpo;
        logic [7:0]  fcfg_x;
        logic [7:0]  fcfg_y;
        logic        status_output_select_x;
        logic        status_output_select_y;
        logic [7:0]  pin_x;
        logic [7:0]  pin_y;
        logic [15:0] sts_x;
        logic [15:0] sts_y;
        logic [17:0] presc_x;
        logic [17:0] presc_y;
    } axf_state_t;

endpackage
